// >>> rtl/rcr_regs.sv
// control register bank of a quad-channel receiver, staged and active copies
// assumes the serial port front end delivers decoded one-cycle read/write strobes
// How it works
// RULE1 - low four select bits mask local writes
// RULE2 - bits seven/six enable CD/AB output ports
// RULE3 - writing one to 0xFF triggers shadow transfer
// RULE4 - power field: normal, full down, standby
// RULE5 - global bit picks power-down pin behaviour
// RULE6 - divide ratio equals code plus one
// RULE7 - phase code delays divided clock cycles
// RULE8 - shuffle field: 00 off, 01 on
// RULE9 - three-bit code selects test pattern
// RULE10 - non-normal code drives test data out
// RULE11 - bit five runs long noise generator
// RULE12 - bit four runs short noise generator
// RULE13 - bit zero starts channel self-test
// RULE14 - bit two releases self-test reset
// RULE15 - shadowed registers update together, bit self-clears
// RULE16 - multi-select read returns channel A value
// RULE17 - global registers ignore channel select
`timescale 1ns/1ps
`default_nettype none
module rcr_regs #(
  parameter int NUM_CH = 4,
  parameter int DW = 11
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // converter side
  input wire logic [NUM_CH-1:0][DW-1:0] adc_data,
  input wire logic pdwn_pin,
  // output data
  output logic [NUM_CH-1:0][DW-1:0] out_data,
  output logic sample_tick,
  output logic port_ab_en,
  output logic port_cd_en,
  // channel controls
  output logic [NUM_CH-1:0][1:0] pwr_mode,
  output logic [NUM_CH-1:0] shuffle_en,
  output logic [NUM_CH-1:0] self_test_run,
  output logic [NUM_CH-1:0] self_test_rst
);
  // ****************************************
  // state
  // ****************************************
  logic [7:0] ch_sel_ff;
  logic xfer_ff;
  logic pd_glob_m_ff, pd_glob_s_ff;
  logic [5:0] div_m_ff, div_s_ff;
  logic [NUM_CH-1:0][1:0] pm_m_ff, pm_s_ff;
  logic [NUM_CH-1:0][1:0] sh_m_ff, sh_s_ff;
  logic [NUM_CH-1:0][7:0] tp_m_ff, tp_s_ff;
  logic [NUM_CH-1:0][7:0] st_m_ff, st_s_ff;
  logic [NUM_CH-1:0][1:0] pwr_mode_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic pd_meta_ff, pd_sync_ff;
  logic [1:0] rd_ch;
  logic wr_xfer;
  logic [7:0] nxt_rdata;

  // a read with zero or several channels selected falls back to channel A
  function automatic logic [1:0] read_channel(input logic [3:0] sel);
    case (sel)
      4'h2: read_channel = 2'h1;
      4'h4: read_channel = 2'h2;
      4'h8: read_channel = 2'h3;
      default: read_channel = 2'h0;
    endcase
  endfunction : read_channel

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = reg_wr && (a == target);
  endfunction : hit

  assign rd_ch = read_channel(ch_sel_ff[3:0]); // RULE16
  assign wr_xfer = hit(reg_addr, rcr_pkg::ADDR_XFER) && reg_wdata[rcr_pkg::BIT_XFER];

  // ****************************************
  // channel select and transfer command
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ch_sel_ff <= rcr_pkg::RST_CHAN_SEL; // RULE1
    else if (hit(reg_addr, rcr_pkg::ADDR_CHAN_SEL))
      ch_sel_ff <= reg_wdata & 8'hCF;
  end

  // self-clearing: set for exactly the cycle in which the copy happens
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      xfer_ff <= 1'b0;
    else
      xfer_ff <= wr_xfer; // RULE3 RULE15
  end

  assign port_cd_en = ch_sel_ff[rcr_pkg::BIT_PORT_CD]; // RULE2
  assign port_ab_en = ch_sel_ff[rcr_pkg::BIT_PORT_AB]; // RULE2

  // ****************************************
  // staged copies of global registers
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pd_glob_m_ff <= rcr_pkg::RST_POWER[rcr_pkg::BIT_PD_PIN_STBY];
      div_m_ff <= rcr_pkg::RST_CLK_DIV[5:0];
    end
    else
    begin
      if (hit(reg_addr, rcr_pkg::ADDR_POWER))
        pd_glob_m_ff <= reg_wdata[rcr_pkg::BIT_PD_PIN_STBY]; // RULE17
      if (hit(reg_addr, rcr_pkg::ADDR_CLK_DIV))
        div_m_ff <= reg_wdata[5:0] & rcr_pkg::MSK_CLK_DIV[5:0]; // RULE17
    end
  end

  // ****************************************
  // staged copies of local registers
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        pm_m_ff[c] <= rcr_pkg::RST_POWER[1:0];
        sh_m_ff[c] <= rcr_pkg::RST_SHUFFLE[1:0];
        tp_m_ff[c] <= rcr_pkg::RST_TEST;
        st_m_ff[c] <= rcr_pkg::RST_SELF_TEST;
      end
    end
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (ch_sel_ff[c]) // RULE1
        begin
          if (hit(reg_addr, rcr_pkg::ADDR_POWER))
            pm_m_ff[c] <= reg_wdata[1:0] & rcr_pkg::MSK_POWER_LOC[1:0];
          if (hit(reg_addr, rcr_pkg::ADDR_SHUFFLE))
            sh_m_ff[c] <= reg_wdata[1:0] & rcr_pkg::MSK_SHUFFLE[1:0];
          if (hit(reg_addr, rcr_pkg::ADDR_TEST))
            tp_m_ff[c] <= reg_wdata & rcr_pkg::MSK_TEST;
          if (hit(reg_addr, rcr_pkg::ADDR_SELF_TEST))
            st_m_ff[c] <= reg_wdata & rcr_pkg::MSK_SELF_TEST;
        end
      end
    end
  end

  // ****************************************
  // active copies, all loaded in one cycle
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pd_glob_s_ff <= rcr_pkg::RST_POWER[rcr_pkg::BIT_PD_PIN_STBY];
      div_s_ff <= rcr_pkg::RST_CLK_DIV[5:0];
      for (int c = 0; c < NUM_CH; c++)
      begin
        pm_s_ff[c] <= rcr_pkg::RST_POWER[1:0];
        sh_s_ff[c] <= rcr_pkg::RST_SHUFFLE[1:0];
        tp_s_ff[c] <= rcr_pkg::RST_TEST;
        st_s_ff[c] <= rcr_pkg::RST_SELF_TEST;
      end
    end
    else if (xfer_ff) // RULE15
    begin
      pd_glob_s_ff <= pd_glob_m_ff;
      div_s_ff <= div_m_ff;
      pm_s_ff <= pm_m_ff;
      sh_s_ff <= sh_m_ff;
      tp_s_ff <= tp_m_ff;
      st_s_ff <= st_m_ff;
    end
  end

  // ****************************************
  // power control
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pd_meta_ff <= 1'b0;
      pd_sync_ff <= 1'b0;
    end
    else
    begin
      pd_meta_ff <= pdwn_pin;
      pd_sync_ff <= pd_meta_ff;
    end
  end

  // the pin overrides the per-channel field while it is asserted
  always_ff @(posedge sys_clk)
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (rst)
        pwr_mode_ff[c] <= rcr_pkg::PM_NORMAL;
      else if (pd_sync_ff)
        pwr_mode_ff[c] <= pd_glob_s_ff ? rcr_pkg::PM_STANDBY : rcr_pkg::PM_FULL_PD; // RULE5
      else if (pm_s_ff[c] == rcr_pkg::PM_FULL_PD || pm_s_ff[c] == rcr_pkg::PM_STANDBY)
        pwr_mode_ff[c] <= pm_s_ff[c]; // RULE4
      else
        pwr_mode_ff[c] <= rcr_pkg::PM_NORMAL; // RULE4
    end
  end

  assign pwr_mode = pwr_mode_ff;

  // ****************************************
  // shuffle and self-test controls
  // ****************************************
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      shuffle_en[c] = (sh_s_ff[c] == rcr_pkg::SHUF_ON); // RULE8
      self_test_rst[c] = !st_s_ff[c][rcr_pkg::BIT_ST_RELEASE]; // RULE14
      self_test_run[c] = st_s_ff[c][rcr_pkg::BIT_ST_START] && st_s_ff[c][rcr_pkg::BIT_ST_RELEASE]; // RULE13
    end
  end

  // ****************************************
  // sample strobe and output data
  // ****************************************
  rcr_clk_div u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .ratio_code(div_s_ff[2:0]),
    .phase_code(div_s_ff[5:rcr_pkg::POS_DIV_PHASE]),
    .tick(sample_tick)
  );

  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    rcr_pattern_gen #(.DW(DW)) u_gen (
      .sys_clk(sys_clk),
      .rst(rst),
      .step(sample_tick),
      .mode(tp_s_ff[g][2:0]),
      .long_run(tp_s_ff[g][rcr_pkg::BIT_LONG_RUN]),
      .short_run(tp_s_ff[g][rcr_pkg::BIT_SHORT_RUN]),
      .sample(adc_data[g]),
      .data(out_data[g])
    );
  end

  // ****************************************
  // read-back of staged values
  // ****************************************
  always_comb
  begin
    case (reg_addr)
      rcr_pkg::ADDR_CHAN_SEL: nxt_rdata = ch_sel_ff;
      rcr_pkg::ADDR_XFER: nxt_rdata = {7'h00, xfer_ff};
      rcr_pkg::ADDR_POWER: nxt_rdata = {2'h0, pd_glob_m_ff, 3'h0, pm_m_ff[rd_ch]}; // RULE16
      rcr_pkg::ADDR_CLK_DIV: nxt_rdata = {2'h0, div_m_ff};
      rcr_pkg::ADDR_SHUFFLE: nxt_rdata = {6'h00, sh_m_ff[rd_ch]}; // RULE16
      rcr_pkg::ADDR_TEST: nxt_rdata = tp_m_ff[rd_ch];
      rcr_pkg::ADDR_SELF_TEST: nxt_rdata = st_m_ff[rd_ch];
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= reg_rd;
      if (reg_rd)
        rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;

  // ****************************************
  // checks
  // ****************************************
  a_xfer_start: assert property (@(posedge sys_clk) disable iff (rst) // RULE3
    wr_xfer |=> xfer_ff ##1 (xfer_ff == $past(wr_xfer)))
    else $error("transfer bit did not pulse once");
  a_shadow_hold: assert property (@(posedge sys_clk) disable iff (rst) // RULE15
    !xfer_ff |=> ($stable(tp_s_ff) && $stable(pm_s_ff) && $stable(div_s_ff)))
    else $error("active copy changed without transfer");
  a_shadow_load: assert property (@(posedge sys_clk) disable iff (rst) // RULE15
    xfer_ff |=> (sh_s_ff == $past(sh_m_ff) && st_s_ff == $past(st_m_ff)))
    else $error("active copy not loaded on transfer");
  a_local_mask: assert property (@(posedge sys_clk) disable iff (rst) // RULE1
    (hit(reg_addr, rcr_pkg::ADDR_SHUFFLE) && !ch_sel_ff[0]) |=> $stable(sh_m_ff[0]))
    else $error("unselected channel took a local write");
  a_global_write: assert property (@(posedge sys_clk) disable iff (rst) // RULE17
    (hit(reg_addr, rcr_pkg::ADDR_CLK_DIV) && ch_sel_ff[3:0] == 4'h0) |=> (div_m_ff == $past(reg_wdata[5:0])))
    else $error("global write blocked by channel select");
  a_read_chan_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE16
    (reg_rd && reg_addr == rcr_pkg::ADDR_SHUFFLE && ch_sel_ff[3:0] == 4'hF && !reg_wr)
    |=> (reg_rvalid && reg_rdata == {6'h00, sh_m_ff[0]}))
    else $error("multi-select read did not return channel A");
  a_pin_power: assert property (@(posedge sys_clk) disable iff (rst) // RULE5
    (pd_sync_ff && !pd_glob_s_ff) |=> (pwr_mode[0] == rcr_pkg::PM_FULL_PD))
    else $error("power-down pin did not force full power-down");
  a_self_test: assert property (@(posedge sys_clk) disable iff (rst) // RULE13
    $rose(self_test_run[2]) |-> $past(xfer_ff) && st_s_ff[2][rcr_pkg::BIT_ST_RELEASE])
    else $error("self-test started without transfer or release");
endmodule : rcr_regs
`default_nettype wire

// >>> rtl/rcr_pkg.sv
// constants of the receiver control register bank
// assumes one clock domain and an 8-bit address / 8-bit data register port
package rcr_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADDR_CHAN_SEL = 8'h05;
  localparam logic [7:0] ADDR_POWER = 8'h08;
  localparam logic [7:0] ADDR_CLK_DIV = 8'h0B;
  localparam logic [7:0] ADDR_SHUFFLE = 8'h0C;
  localparam logic [7:0] ADDR_TEST = 8'h0D;
  localparam logic [7:0] ADDR_SELF_TEST = 8'h0E;
  localparam logic [7:0] ADDR_XFER = 8'hFF;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_CHAN_SEL = 8'hCF;
  localparam logic [7:0] RST_POWER = 8'h00;
  localparam logic [7:0] RST_CLK_DIV = 8'h00;
  localparam logic [7:0] RST_SHUFFLE = 8'h01;
  localparam logic [7:0] RST_TEST = 8'h30;
  localparam logic [7:0] RST_SELF_TEST = 8'h04;
  // ****************************************
  // writable bit masks and field positions
  // ****************************************
  localparam logic [7:0] MSK_POWER_LOC = 8'h03;
  localparam logic [7:0] MSK_CLK_DIV = 8'h3F;
  localparam logic [7:0] MSK_SHUFFLE = 8'h03;
  localparam logic [7:0] MSK_TEST = 8'h37;
  localparam logic [7:0] MSK_SELF_TEST = 8'h05;
  localparam int BIT_PORT_CD = 7;
  localparam int BIT_PORT_AB = 6;
  localparam int BIT_PD_PIN_STBY = 5;
  localparam int BIT_LONG_RUN = 5;
  localparam int BIT_SHORT_RUN = 4;
  localparam int BIT_ST_RELEASE = 2;
  localparam int BIT_ST_START = 0;
  localparam int BIT_XFER = 0;
  localparam int POS_DIV_PHASE = 3;
  // ****************************************
  // field codes
  // ****************************************
  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam logic [1:0] PM_FULL_PD = 2'h1;
  localparam logic [1:0] PM_STANDBY = 2'h2;
  localparam logic [1:0] SHUF_ON = 2'h1;
  localparam logic [2:0] TP_NORMAL = 3'h0;
  localparam logic [2:0] TP_MIDSCALE = 3'h1;
  localparam logic [2:0] TP_POS_FULL_SCALE = 3'h2;
  localparam logic [2:0] TP_NEG_FULL_SCALE = 3'h3;
  localparam logic [2:0] TP_CHECKER = 3'h4;
  localparam logic [2:0] TP_PN_LONG = 3'h5;
  localparam logic [2:0] TP_PN_SHORT = 3'h6;
  localparam logic [2:0] TP_TOGGLE = 3'h7;
endpackage : rcr_pkg

// >>> rtl/rcr_clk_div.sv
// integer divider of the sample clock with whole-cycle phase delay
// assumes codes come from the active (post-transfer) register copy
`timescale 1ns/1ps
`default_nettype none
module rcr_clk_div (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // settings
  input wire logic [2:0] ratio_code,
  input wire logic [2:0] phase_code,
  // divided strobe
  output logic tick
);
  logic [2:0] cnt_ff;
  // seven taps cover the largest phase code
  logic [6:0] hist_ff;
  logic tick_ff;
  logic base;

  // code plus one is the ratio, so code 0 fires every cycle
  assign base = (cnt_ff == ratio_code); // RULE6

  always_ff @(posedge sys_clk)
  begin
    if (rst || base)
      cnt_ff <= 3'h0;
    else
      cnt_ff <= cnt_ff + 3'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      hist_ff <= 7'h00;
    else
      hist_ff <= {hist_ff[5:0], base};
  end

  // delay by the phase code in whole cycles
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      tick_ff <= 1'b0;
    else if (phase_code == 3'h0)
      tick_ff <= base; // RULE7
    else
      tick_ff <= hist_ff[phase_code - 3'h1]; // RULE7
  end

  assign tick = tick_ff;

  a_phase_zero: assert property (@(posedge sys_clk) disable iff (rst) // RULE7
    (phase_code == 3'h0 && base) |=> tick)
    else $error("divided strobe not aligned for zero phase");
  a_phase_delay: assert property (@(posedge sys_clk) disable iff (rst) // RULE7
    (phase_code == 3'h3 && base) ##1 (phase_code == 3'h3) [*3] |=> tick)
    else $error("divided strobe not delayed by phase code");
endmodule : rcr_clk_div
`default_nettype wire

// >>> rtl/rcr_pattern_gen.sv
// per-channel output selector: converted samples or a generated test word
// assumes step pulses once per divided sample period
`timescale 1ns/1ps
`default_nettype none
module rcr_pattern_gen #(
  parameter int DW = 11
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic step,
  input wire logic [2:0] mode,
  input wire logic long_run,
  input wire logic short_run,
  // data
  input wire logic [DW-1:0] sample,
  output logic [DW-1:0] data
);
  logic [22:0] long_ff;
  logic [8:0] short_ff;
  logic phase_ff;
  logic [DW-1:0] data_ff;
  logic [DW-1:0] alt_a;

  // the pair pattern is one bit wider than an odd word, so cut it to size
  assign alt_a = DW'({(DW+1)/2{2'b01}});

  // ****************************************
  // pseudo-noise generators, held at seed while in reset
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst || !long_run)
      long_ff <= '1; // RULE11
    else if (step)
      long_ff <= {long_ff[21:0], long_ff[22] ^ long_ff[17]};
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || !short_run)
      short_ff <= '1; // RULE12
    else if (step)
      short_ff <= {short_ff[7:0], short_ff[8] ^ short_ff[4]};
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      phase_ff <= 1'b0;
    else if (step)
      phase_ff <= !phase_ff;
  end

  // ****************************************
  // output word
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      data_ff <= '0;
    else if (step)
    begin
      case (mode) // RULE9 RULE10
        rcr_pkg::TP_NORMAL: data_ff <= sample;
        rcr_pkg::TP_MIDSCALE: data_ff <= {1'b1, {(DW-1){1'b0}}};
        rcr_pkg::TP_POS_FULL_SCALE: data_ff <= '1;
        rcr_pkg::TP_NEG_FULL_SCALE: data_ff <= '0;
        rcr_pkg::TP_CHECKER: data_ff <= phase_ff ? ~alt_a : alt_a;
        rcr_pkg::TP_PN_LONG: data_ff <= long_ff[DW-1:0];
        rcr_pkg::TP_PN_SHORT: data_ff <= {{(DW-9){1'b0}}, short_ff};
        rcr_pkg::TP_TOGGLE: data_ff <= phase_ff ? '0 : '1;
        default: data_ff <= sample;
      endcase
    end
  end

  assign data = data_ff;

  a_pos_full: assert property (@(posedge sys_clk) disable iff (rst) // RULE10
    (step && mode == rcr_pkg::TP_POS_FULL_SCALE) |=> (data == '1))
    else $error("test word replaced by wrong data");
endmodule : rcr_pattern_gen
`default_nettype wire

// >>> verif/rcr_host_model.sv
// host model of the serial control port: issues one-cycle register strobes
// assumes strobes are sampled on the rising edge; it drives on the falling edge
`timescale 1ns/1ps
`default_nettype none
module rcr_host_model (
  // clock
  input wire logic sys_clk,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // released address and data lines get inverted so a stale value is never mistaken for a real one
  task automatic drive(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : drive
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    drive(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    drive(1'b0, a, 8'h00);
  endtask : rd
  // channel mask picks which local copies the next writes reach
  task automatic sel(input logic [7:0] m);
    wr(rcr_pkg::ADDR_CHAN_SEL, m);
  endtask : sel
  // staged settings take effect only after this; wait covers load plus output stage
  task automatic xfer();
    wr(rcr_pkg::ADDR_XFER, 8'h01);
    repeat (3) @(negedge sys_clk);
  endtask : xfer
endmodule : rcr_host_model
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench of the receiver control register bank
// assumes the host model drives the register port; reads are checked from a queue
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  // ****************************************
  // signals
  // ****************************************
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr, reg_rd, reg_rvalid, pdwn_pin, sample_tick, port_ab_en, port_cd_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, e_v;
  logic [3:0][10:0] adc_data, out_data;
  logic [3:0][1:0] pwr_mode;
  logic [3:0] shuffle_en, self_test_run, self_test_rst;
  logic [63:0] rnd;
  logic [7:0] exp_q[$];
  logic [10:0] pv, pa;
  int fails = 0;
  int checked = 0;
  int seed = 32'h03876a3d;
  int n;
  logic [7:0] ra[8] = '{8'h05, 8'h08, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'hFF, 8'h13};
  logic [7:0] rv[8] = '{8'hCF, 8'h00, 8'h00, 8'h01, 8'h30, 8'h04, 8'h00, 8'h00};
  logic [2:0] pc[6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h0};
  logic [21:0] pe[6] = '{{11'h400, 11'h400}, {11'h7FF, 11'h7FF}, {11'h000, 11'h000},
    {11'h555, 11'h2AA}, {11'h7FF, 11'h000}, 22'h0};
  always #12.5 sys_clk = ~sys_clk;
  rcr_host_model host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  rcr_regs dut (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .adc_data(adc_data),
    .pdwn_pin(pdwn_pin), .out_data(out_data), .sample_tick(sample_tick), .port_ab_en(port_ab_en),
    .port_cd_en(port_cd_en), .pwr_mode(pwr_mode), .shuffle_en(shuffle_en),
    .self_test_run(self_test_run), .self_test_rst(self_test_rst));
  // ****************************************
  // read answers against the oldest note
  // ****************************************
  // sampled mid-cycle, away from the edge that launches the answer
  always @(negedge sys_clk)
  begin
    if (reg_rvalid === 1'b1)
    begin
      e_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      `CHK(reg_rdata, e_v)
    end
  end
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask : rd_exp
  // gap in cycles between two ticks, bounded so a dead divider cannot hang
  task automatic gap(output int g);
    int k;
    k = 0;
    while (sample_tick !== 1'b1 && k < 40)
    begin
      @(negedge sys_clk);
      k++;
    end
    g = 0;
    do
    begin
      @(negedge sys_clk);
      g++;
    end
    while (sample_tick !== 1'b1 && g < 40);
  endtask : gap
  task automatic pat(input logic [7:0] v, output logic [10:0] a, output logic [10:0] b);
    host.wr(rcr_pkg::ADDR_TEST, v);
    host.xfer();
    repeat (2) @(negedge sys_clk);
    a = out_data[0];
    @(negedge sys_clk);
    b = out_data[0];
  endtask : pat
  // counts words that differ from the first one over thirty ticks
  task automatic pn(input logic [7:0] v, input logic moved);
    int c;
    pat(v, pv, pa);
    c = 0;
    repeat (30)
    begin
      @(negedge sys_clk);
      c += (out_data[0] !== pv);
    end
    `CHK(c > 0, moved)
  endtask : pn
  task automatic finish_test();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial
  begin
    #(25 * 20000);
    fails++;
    finish_test();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    pdwn_pin = 1'b0;
    rnd = {$random(seed), $random(seed)};
    adc_data = rnd[43:0];
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++)
      rd_exp(ra[i], rv[i]);
    `CHK({port_cd_en, port_ab_en, shuffle_en}, 6'h3F)
    host.sel(8'h82);
    @(negedge sys_clk);
    `CHK({port_cd_en, port_ab_en}, 2'h2)
    host.wr(rcr_pkg::ADDR_SHUFFLE, 8'h00);
    host.wr(8'h13, 8'hAA);
    `CHK(shuffle_en, 4'hF)
    host.xfer();
    `CHK(shuffle_en, 4'hD)
    rd_exp(rcr_pkg::ADDR_XFER, 8'h00);
    rd_exp(rcr_pkg::ADDR_SHUFFLE, 8'h00);
    rd_exp(8'h13, 8'h00);
    host.sel(8'h03);
    rd_exp(rcr_pkg::ADDR_SHUFFLE, 8'h01);
    host.sel(8'hC0);
    for (int r = 0; r < 8; r++)
    begin
      // phase walks down as ratio walks up, so every code of both fields is used
      host.wr(rcr_pkg::ADDR_CLK_DIV, {2'h0, ~r[2:0], r[2:0]});
      rd_exp(rcr_pkg::ADDR_CLK_DIV, {2'h0, ~r[2:0], r[2:0]});
      host.xfer();
      // stale delay history and an overrun counter need some cycles to drain
      repeat (20) @(negedge sys_clk);
      gap(n);
      gap(n);
      `CHK(n, r + 1)
    end
    host.wr(rcr_pkg::ADDR_CLK_DIV, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      host.sel(8'h01 << i);
      host.wr(rcr_pkg::ADDR_POWER, i[7:0]);
    end
    host.xfer();
    `CHK(pwr_mode, 8'h24)
    pdwn_pin = 1'b1;
    repeat (5) @(negedge sys_clk);
    `CHK(pwr_mode, 8'h55)
    host.sel(8'h01);
    host.wr(rcr_pkg::ADDR_POWER, 8'h20);
    host.xfer();
    `CHK(pwr_mode, 8'hAA)
    pdwn_pin = 1'b0;
    repeat (5) @(negedge sys_clk);
    `CHK(pwr_mode, 8'h24)
    host.sel(8'h04);
    host.wr(rcr_pkg::ADDR_SELF_TEST, 8'h05);
    host.xfer();
    `CHK({self_test_run, self_test_rst}, 8'h40)
    host.wr(rcr_pkg::ADDR_SELF_TEST, 8'h01);
    host.xfer();
    `CHK({self_test_run, self_test_rst}, 8'h04)
    host.sel(8'h01);
    for (int i = 0; i < 6; i++)
    begin
      // fresh converter samples for every pattern, so normal mode passes live data
      rnd = {$random(seed), $random(seed)};
      adc_data = rnd[43:0];
      pe[5] = {adc_data[0], adc_data[0]};
      pat({5'h06, pc[i]}, pv, pa);
      `CHK(pv === pe[i][21:11] || pv === pe[i][10:0], 1'b1)
      `CHK(pa, (pv === pe[i][21:11]) ? pe[i][10:0] : pe[i][21:11])
    end
    pn(8'h05, 1'b0);
    pn(8'h25, 1'b1);
    pn(8'h06, 1'b0);
    pn(8'h16, 1'b1);
    repeat (3) @(negedge sys_clk);
    `CHK(exp_q.size(), 0)
    finish_test();
  end
endmodule : testbench
`default_nettype wire
